/* File: emrd_pkg.sv */
// constants and types shared by the extended move/or/rotate datapath
`default_nettype none
package emrd_pkg;
  // ==========================================
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int MSB_POS = 7;
  localparam int LSB_POS = 0;
  // ==========================================
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] MEM_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic ZERO_RESET = 1'b0;
  // ==========================================
  // operation codes presented on the op port
  typedef enum logic [3:0] {
    EMRD_NOP = 4'h0,
    EMRD_MOV_TO_ACC = 4'h1,
    EMRD_MOV_TO_MEM = 4'h2,
    EMRD_OR_TO_ACC = 4'h3,
    EMRD_OR_TO_MEM = 4'h4,
    EMRD_ROTL_INPLACE = 4'h5,
    EMRD_ROTL_TO_ACC = 4'h6,
    EMRD_ROTL_C_INPLACE = 4'h7,
    EMRD_ROTL_C_TO_ACC = 4'h8,
    EMRD_ROTR_INPLACE = 4'h9,
    EMRD_ROTR_TO_ACC = 4'hA
  } emrd_op_t;
endpackage
`default_nettype wire

/* File: emrd_alu.sv */
// combinational result and flag logic for one extended instruction
`timescale 1ns/1ps
`default_nettype none
module emrd_alu (
  input wire emrd_pkg::emrd_op_t op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] mem_i,
  input wire logic carry_i,
  output logic [7:0] result_o,
  output logic carry_o,
  output logic to_acc_o,
  output logic to_mem_o,
  output logic zero_upd_o,
  output logic carry_upd_o
);
  import emrd_pkg::*;

  // ==========================================
  // rotate helpers, shared by in-place and to-acc forms
  function automatic logic [7:0] rotl(input logic [7:0] v, input logic in_bit);
    rotl = {v[MSB_POS-1:LSB_POS], in_bit};
  endfunction

  function automatic logic [7:0] rotr(input logic [7:0] v, input logic in_bit);
    rotr = {in_bit, v[MSB_POS:LSB_POS+1]};
  endfunction

  wire logic [7:0] or_val = acc_i | mem_i;

  // result and destination selection per operation
  always_comb begin
    result_o = mem_i;
    carry_o = carry_i;
    to_acc_o = 1'b0;
    to_mem_o = 1'b0;
    zero_upd_o = 1'b0;
    carry_upd_o = 1'b0;
    unique case (op_i)
      EMRD_MOV_TO_ACC: begin
        result_o = mem_i;
        to_acc_o = 1'b1;
      end
      EMRD_MOV_TO_MEM: begin
        result_o = acc_i;
        to_mem_o = 1'b1;
      end
      EMRD_OR_TO_ACC: begin
        result_o = or_val;
        to_acc_o = 1'b1;
        zero_upd_o = 1'b1;
      end
      EMRD_OR_TO_MEM: begin
        result_o = or_val;
        to_mem_o = 1'b1;
        zero_upd_o = 1'b1;
      end
      EMRD_ROTL_INPLACE: begin
        result_o = rotl(mem_i, mem_i[MSB_POS]);
        to_mem_o = 1'b1;
      end
      EMRD_ROTL_TO_ACC: begin
        result_o = rotl(mem_i, mem_i[MSB_POS]);
        to_acc_o = 1'b1;
      end
      EMRD_ROTL_C_INPLACE: begin
        result_o = rotl(mem_i, carry_i);
        carry_o = mem_i[MSB_POS];
        to_mem_o = 1'b1;
        carry_upd_o = 1'b1;
      end
      EMRD_ROTL_C_TO_ACC: begin
        result_o = rotl(mem_i, carry_i);
        carry_o = mem_i[MSB_POS];
        to_acc_o = 1'b1;
        carry_upd_o = 1'b1;
      end
      EMRD_ROTR_INPLACE: begin
        result_o = rotr(mem_i, mem_i[LSB_POS]);
        to_mem_o = 1'b1;
      end
      EMRD_ROTR_TO_ACC: begin
        result_o = rotr(mem_i, mem_i[LSB_POS]);
        to_acc_o = 1'b1;
      end
      // unused codes do nothing, like a nop
      default: begin
        result_o = mem_i;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: emrd_core.sv */
// extended move / or / rotate datapath with accumulator, flags and data memory
`timescale 1ns/1ps
`default_nettype none
module emrd_core (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic EXEC_I,
  input wire emrd_pkg::emrd_op_t OP_I,
  input wire logic [emrd_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [emrd_pkg::ADDR_W-1:0] PEEK_ADDR_I,
  input wire logic ACC_LOAD_I,
  input wire logic [emrd_pkg::DATA_W-1:0] ACC_LOAD_DATA_I,
  output logic [emrd_pkg::DATA_W-1:0] ACC_O,
  output logic CARRY_O,
  output logic ZERO_O,
  output logic [emrd_pkg::DATA_W-1:0] PEEK_DATA_O,
  output logic DONE_O
);
  import emrd_pkg::*;

  // ==========================================
  // state
  logic [7:0] mem_reg [MEM_DEPTH];
  logic [7:0] acc_reg;
  logic carry_reg;
  logic zero_reg;
  logic [7:0] peek_reg;
  logic done_reg;

  // ==========================================
  // decode
  wire logic [7:0] mem_rd = mem_reg[ADDR_I];
  wire logic [7:0] alu_result;
  wire logic alu_carry;
  wire logic alu_to_acc;
  wire logic alu_to_mem;
  wire logic alu_zero_upd;
  wire logic alu_carry_upd;

  emrd_alu u_alu (
    .op_i(OP_I),
    .acc_i(acc_reg),
    .mem_i(mem_rd),
    .carry_i(carry_reg),
    .result_o(alu_result),
    .carry_o(alu_carry),
    .to_acc_o(alu_to_acc),
    .to_mem_o(alu_to_mem),
    .zero_upd_o(alu_zero_upd),
    .carry_upd_o(alu_carry_upd)
  );

  // write enables gated by the execute strobe
  wire logic acc_we = EXEC_I && alu_to_acc;
  wire logic mem_we = EXEC_I && alu_to_mem;
  wire logic zero_we = EXEC_I && alu_zero_upd;
  wire logic carry_we = EXEC_I && alu_carry_upd;
  wire logic zero_next = (alu_result == ZERO_BYTE);
  // an op that writes the accumulator outranks a direct load; a load under any other op still fills it
  wire logic [7:0] acc_held = ACC_LOAD_I ? ACC_LOAD_DATA_I : acc_reg;
  wire logic [7:0] acc_next = acc_we ? alu_result : acc_held;
  wire logic carry_next = carry_we ? alu_carry : carry_reg;

  // ==========================================
  // accumulator and flags
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      acc_reg <= ACC_RESET;
      carry_reg <= CARRY_RESET;
      zero_reg <= ZERO_RESET;
      done_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      if (zero_we) begin
        zero_reg <= zero_next;
      end
      done_reg <= EXEC_I;
    end
  end

  // data memory; reset clears it so reads are never unknown
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_reg[i] <= MEM_RESET;
      end
    end else if (mem_we) begin
      mem_reg[ADDR_I] <= alu_result;
    end
  end

  // registered view port, one cycle behind the memory contents
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      peek_reg <= MEM_RESET;
    end else begin
      peek_reg <= mem_reg[PEEK_ADDR_I];
    end
  end

  assign ACC_O = acc_reg;
  assign CARRY_O = carry_reg;
  assign ZERO_O = zero_reg;
  assign PEEK_DATA_O = peek_reg;
  assign DONE_O = done_reg;

  // ==========================================
  // checks
  property p_mov_acc;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && OP_I == EMRD_MOV_TO_ACC) |=> (acc_reg == $past(mem_rd)) && $stable(zero_reg) && $stable(carry_reg);
  endproperty
  a_mov_acc: assert property (p_mov_acc) else $error("move to acc wrong");

  property p_mov_mem;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && OP_I == EMRD_MOV_TO_MEM) |=> (mem_reg[$past(ADDR_I)] == $past(acc_reg)) && $stable(zero_reg);
  endproperty
  a_mov_mem: assert property (p_mov_mem) else $error("move to mem wrong");

  property p_or_acc;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && OP_I == EMRD_OR_TO_ACC) |=> (acc_reg == ($past(acc_reg) | $past(mem_rd))) && $stable(carry_reg);
  endproperty
  a_or_acc: assert property (p_or_acc) else $error("or to acc wrong");

  property p_or_mem;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && OP_I == EMRD_OR_TO_MEM) |=> (mem_reg[$past(ADDR_I)] == ($past(acc_reg) | $past(mem_rd))) && $stable(acc_reg);
  endproperty
  a_or_mem: assert property (p_or_mem) else $error("or to mem wrong");

  property p_rotl;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && OP_I == EMRD_ROTL_INPLACE) |=> (mem_reg[$past(ADDR_I)] == {$past(mem_rd[6:0]), $past(mem_rd[7])}) && $stable(carry_reg);
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate left wrong");

  property p_rotl_acc;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && OP_I == EMRD_ROTL_TO_ACC) |=> (acc_reg == {$past(mem_rd[6:0]), $past(mem_rd[7])}) && $stable(zero_reg);
  endproperty
  a_rotl_acc: assert property (p_rotl_acc) else $error("rotate left to acc wrong");

  property p_rotlc;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && OP_I == EMRD_ROTL_C_INPLACE) |=> (mem_reg[$past(ADDR_I)] == {$past(mem_rd[6:0]), $past(carry_reg)}) && (carry_reg == $past(mem_rd[7]));
  endproperty
  a_rotlc: assert property (p_rotlc) else $error("rotate left carry wrong");

  property p_rotlc_acc;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && OP_I == EMRD_ROTL_C_TO_ACC) |=> (acc_reg == {$past(mem_rd[6:0]), $past(carry_reg)}) && (carry_reg == $past(mem_rd[7]));
  endproperty
  a_rotlc_acc: assert property (p_rotlc_acc) else $error("rotate left carry to acc wrong");

  property p_rotr;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && OP_I == EMRD_ROTR_INPLACE) |=> (mem_reg[$past(ADDR_I)] == {$past(mem_rd[0]), $past(mem_rd[7:1])}) && $stable(carry_reg);
  endproperty
  a_rotr: assert property (p_rotr) else $error("rotate right wrong");

  property p_rotr_acc;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && OP_I == EMRD_ROTR_TO_ACC) |=> (acc_reg == {$past(mem_rd[0]), $past(mem_rd[7:1])}) && $stable(zero_reg);
  endproperty
  a_rotr_acc: assert property (p_rotr_acc) else $error("rotate right to acc wrong");

  property p_zero;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && (OP_I == EMRD_OR_TO_ACC || OP_I == EMRD_OR_TO_MEM)) |=> (zero_reg == (($past(acc_reg) | $past(mem_rd)) == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  // ==========================================
  // op classes for the hold checks, decoded apart from the alu so a wrong alu flag shows
  wire logic op_is_or = (OP_I == EMRD_OR_TO_ACC) || (OP_I == EMRD_OR_TO_MEM);
  wire logic op_is_carry = (OP_I == EMRD_ROTL_C_INPLACE) || (OP_I == EMRD_ROTL_C_TO_ACC);
  wire logic op_keeps_mem = (OP_I == EMRD_ROTL_TO_ACC) || (OP_I == EMRD_ROTL_C_TO_ACC) ||
    (OP_I == EMRD_ROTR_TO_ACC);
  wire logic op_defined = (OP_I >= EMRD_MOV_TO_ACC) && (OP_I <= EMRD_ROTR_TO_ACC);

  property p_zero_hold;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && !op_is_or) |=> $stable(zero_reg);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero flag moved by a non-or op");

  property p_carry_hold;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && !op_is_carry) |=> $stable(carry_reg);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("carry moved by a non-carry op");

  property p_mem_kept;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && op_keeps_mem) |=> (mem_reg[$past(ADDR_I)] == $past(mem_rd));
  endproperty
  a_mem_kept: assert property (p_mem_kept) else $error("to-acc op changed memory");

  property p_refused;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (EXEC_I && !op_defined) |=> $stable(acc_reg) && $stable(carry_reg) && $stable(zero_reg) &&
      (mem_reg[$past(ADDR_I)] == $past(mem_rd));
  endproperty
  a_refused: assert property (p_refused) else $error("unused code changed state");

  property p_mem_idle;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    !EXEC_I |=> (mem_reg[$past(ADDR_I)] == $past(mem_rd));
  endproperty
  a_mem_idle: assert property (p_mem_idle) else $error("memory written without execute");

  property p_acc_idle;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (!EXEC_I && !ACC_LOAD_I) |=> $stable(acc_reg);
  endproperty
  a_acc_idle: assert property (p_acc_idle) else $error("accumulator moved while idle");

  property p_acc_load;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (ACC_LOAD_I && !EXEC_I) |=> (acc_reg == $past(ACC_LOAD_DATA_I)) && $stable(carry_reg) && $stable(zero_reg);
  endproperty
  a_acc_load: assert property (p_acc_load) else $error("direct load wrong");

  property p_done;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    EXEC_I |=> done_reg;
  endproperty
  a_done: assert property (p_done) else $error("done missing after execute");

  property p_done_drop;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    !EXEC_I |=> !done_reg;
  endproperty
  a_done_drop: assert property (p_done_drop) else $error("done without execute");
endmodule
`default_nettype wire

/* File: emrd_core_bench.sv */
// self-checking bench for the extended move/or/rotate datapath
`timescale 1ns/1ps
`default_nettype none
module emrd_core_bench;
  import emrd_pkg::*;
  logic clk;
  logic rst_n;
  logic exec;
  emrd_op_t op;
  logic [7:0] addr;
  logic [7:0] peek_addr;
  logic [7:0] acc;
  logic carry;
  logic zero;
  logic [7:0] peek;
  logic done;
  logic acc_load;
  logic [7:0] acc_load_data;
  int mismatches;
  int check_count;
  logic [7:0] m_acc;
  logic m_c;
  logic m_z;
  logic [7:0] m_mem [256];

  // ==========================================
  // device under test
  emrd_core uut (
    .SYS_CLK_I(clk),
    .RESET_N_I(rst_n),
    .EXEC_I(exec),
    .OP_I(op),
    .ADDR_I(addr),
    .PEEK_ADDR_I(peek_addr),
    .ACC_LOAD_I(acc_load),
    .ACC_LOAD_DATA_I(acc_load_data),
    .ACC_O(acc),
    .CARRY_O(carry),
    .ZERO_O(zero),
    .PEEK_DATA_O(peek),
    .DONE_O(done)
  );

  // 25 MHz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // ==========================================
  // shared helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // reference state after reset: everything cleared
  task automatic model_reset();
    m_acc = ACC_RESET;
    m_c = CARRY_RESET;
    m_z = ZERO_RESET;
    foreach (m_mem[i]) m_mem[i] = MEM_RESET;
  endtask

  // expected effect of one operation; flags touched only where listed
  task automatic model(input emrd_op_t o, input logic [7:0] a);
    logic [7:0] b;
    b = m_mem[a];
    case (o)
      EMRD_MOV_TO_ACC: m_acc = b;
      EMRD_MOV_TO_MEM: m_mem[a] = m_acc;
      EMRD_OR_TO_ACC: begin
        m_acc = m_acc | b;
        m_z = (m_acc == ZERO_BYTE);
      end
      EMRD_OR_TO_MEM: begin
        m_mem[a] = m_acc | b;
        m_z = (m_mem[a] == ZERO_BYTE);
      end
      EMRD_ROTL_INPLACE: m_mem[a] = {b[6:0], b[7]};
      EMRD_ROTL_TO_ACC: m_acc = {b[6:0], b[7]};
      EMRD_ROTL_C_INPLACE: begin
        m_mem[a] = {b[6:0], m_c};
        m_c = b[7];
      end
      EMRD_ROTL_C_TO_ACC: begin
        m_acc = {b[6:0], m_c};
        m_c = b[7];
      end
      EMRD_ROTR_INPLACE: m_mem[a] = {b[0], b[7:1]};
      EMRD_ROTR_TO_ACC: m_acc = {b[0], b[7:1]};
      default: ;
    endcase
  endtask

  task automatic check_state();
    check(acc, m_acc, "accumulator");
    check({7'h00, carry}, {7'h00, m_c}, "carry");
    check({7'h00, zero}, {7'h00, m_z}, "zero");
  endtask

  // one operation, results one edge later, memory seen one edge after that
  task automatic run_op(input emrd_op_t o, input logic [7:0] a);
    @(posedge clk);
    exec <= 1'h1;
    op <= o;
    addr <= a;
    peek_addr <= a;
    @(posedge clk);
    exec <= 1'h0;
    model(o, a);
    #1;
    check_state();
    check({7'h00, done}, 8'h01, "done pulse");
    @(posedge clk);
    #1;
    check(peek, m_mem[a], "memory byte");
    check({7'h00, done}, 8'h00, "done fell");
  endtask

  // direct accumulator load, the only way fresh data enters the datapath
  task automatic load_acc(input logic [7:0] v);
    @(posedge clk);
    acc_load <= 1'h1;
    acc_load_data <= v;
    @(posedge clk);
    acc_load <= 1'h0;
    m_acc = v;
    #1;
    check_state();
  endtask

  // place a byte in memory through the accumulator
  task automatic store(input logic [7:0] a, input logic [7:0] v);
    load_acc(v);
    run_op(EMRD_MOV_TO_MEM, a);
  endtask

  // ==========================================
  // scenarios
  task automatic test_moves();
    store(8'h00, 8'h01);
    store(8'h80, 8'h80);
    store(8'hFF, 8'h81);
    store(8'h01, 8'h7E);
    store(8'h22, 8'hC3);
    store(8'h10, 8'h5A);
    store(8'h3C, 8'hA5);
    load_acc(8'h00);
    run_op(EMRD_MOV_TO_ACC, 8'h3C);
    check(acc, 8'hA5, "move from memory");
    run_op(EMRD_MOV_TO_MEM, 8'h44);
  endtask

  // zero flag set by or, then held through every non-or op code from 1 to 10
  task automatic test_or_and_flags();
    load_acc(8'h00);
    run_op(EMRD_ROTL_C_INPLACE, 8'hFF);
    check({7'h00, carry}, 8'h01, "carry from bit 7");
    run_op(EMRD_OR_TO_ACC, 8'h05);
    check({7'h00, zero}, 8'h01, "zero after or");
    run_op(EMRD_OR_TO_MEM, 8'h06);
    for (int k = 1; k <= 10; k++) begin
      if (k != 3 && k != 4) run_op(emrd_op_t'(k[3:0]), 8'h80);
    end
    check({7'h00, zero}, 8'h01, "zero held");
    run_op(EMRD_OR_TO_ACC, 8'h3C);
    check({7'h00, zero}, 8'h00, "zero cleared by or");
    load_acc(8'h00);
    run_op(EMRD_OR_TO_ACC, 8'h05);
    run_op(EMRD_OR_TO_MEM, 8'h3C);
    check(peek, 8'hA5, "or into memory");
    check({7'h00, zero}, 8'h00, "zero cleared by or to memory");
  endtask

  // every rotate at the boundary addresses
  task automatic test_rotates();
    logic [7:0] adr [3] = '{8'h00, 8'h80, 8'hFF};
    foreach (adr[j]) begin
      for (int k = 5; k <= 10; k++) run_op(emrd_op_t'(k[3:0]), adr[j]);
    end
  endtask

  // unused codes change nothing but still pulse done
  task automatic test_refused();
    run_op(EMRD_NOP, 8'h10);
    for (int k = 11; k <= 15; k++) run_op(emrd_op_t'(k[3:0]), 8'h10);
  endtask

  // back-to-back: the second op must see the first op's memory result
  task automatic test_back_to_back();
    @(posedge clk);
    exec <= 1'h1;
    op <= EMRD_ROTL_C_INPLACE;
    addr <= 8'h22;
    peek_addr <= 8'h22;
    @(posedge clk);
    op <= EMRD_ROTR_TO_ACC;
    model(EMRD_ROTL_C_INPLACE, 8'h22);
    #1;
    check_state();
    @(posedge clk);
    exec <= 1'h0;
    model(EMRD_ROTR_TO_ACC, 8'h22);
    #1;
    check_state();
    check(peek, m_mem[8'h22], "memory after pair");
  endtask

  // reset in mid-run clears the flags again
  task automatic test_mid_reset();
    run_op(EMRD_OR_TO_ACC, 8'h01);
    @(posedge clk);
    rst_n <= 1'h0;
    #1;
    model_reset();
    check_state();
    check(peek, 8'h00, "view port in reset");
    check({7'h00, done}, 8'h00, "done in reset");
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    run_op(EMRD_MOV_TO_ACC, 8'h3C);
    check(acc, 8'h00, "memory cleared by reset");
    run_op(EMRD_ROTL_C_TO_ACC, 8'h01);
  endtask

  // ==========================================
  // main sequence
  initial begin
    mismatches = 0;
    check_count = 0;
    rst_n <= 1'h0;
    exec <= 1'h0;
    op <= EMRD_NOP;
    addr <= 8'h00;
    peek_addr <= 8'h00;
    acc_load <= 1'h0;
    acc_load_data <= 8'h00;
    model_reset();
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    check_state();
    test_moves();
    test_or_and_flags();
    test_rotates();
    test_refused();
    test_back_to_back();
    test_mid_reset();
    complete_run();
  end
endmodule
`default_nettype wire
